// ===== include/exec_map.svh
// constants for the add and bit-operation execution datapath
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

// destination select codes
`define DEST_ACC 1'h0
`define DEST_REG 1'h1

// reset values of the accumulator and status flags
`define ACC_RESET 8'h00
`define FLAG_RESET 1'h0

// half-carry is the carry out of this bit position
`define HALF_BIT 3

// timing: one clock per instruction period, a taken skip lasts two periods
`define CLK_PERIOD_NS 100
`define INSTR_PERIOD_NS 100
`define INSTR_CYCLES (`INSTR_PERIOD_NS / `CLK_PERIOD_NS)
`define SKIP_PERIODS 2
`define SKIP_CYCLES (`SKIP_PERIODS * `INSTR_CYCLES)

`endif

// ===== include/exec_pkg.sv
// types shared by the execution datapath
package exec_pkg;

    // operation presented by the decoder
    typedef enum logic [3:0] {
        idle_op,
        add_immediate,
        add_register,
        and_immediate,
        and_register,
        bit_clear_op,
        bit_set_op,
        skip_if_bit_one,
        skip_if_bit_zero
    } op_t;

    // sequencing state of the executor
    typedef enum logic {
        run_st,
        squash_st
    } exec_state_t;

endpackage

// ===== src/alu_core.sv
// combinational adder, and-unit and bit modifier
`timescale 1ns/1ns
`include "exec_map.svh"

module alu_core #(
    parameter int DATA_W = 8
) (
    input wire exec_pkg::op_t op_code,
    input wire logic [DATA_W-1:0] acc,
    input wire logic [DATA_W-1:0] operand,
    input wire logic [2:0] bit_idx,
    output logic [DATA_W-1:0] result,
    output logic carry_out,
    output logic half_out,
    output logic zero_out
);

    logic [DATA_W:0] sum_full;
    logic [`HALF_BIT+1:0] sum_low;
    logic [DATA_W-1:0] bit_mask;

    // one-hot mask of the selected bit
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi = gi + 1)
        begin : g_mask
            assign bit_mask[gi] = (bit_idx == 3'(gi));
        end
    endgenerate

    // carry out of the top bit and out of the low nibble
    assign sum_full = {1'h0, acc} + {1'h0, operand};
    assign sum_low = {1'h0, acc[`HALF_BIT:0]} + {1'h0, operand[`HALF_BIT:0]};
    assign carry_out = sum_full[DATA_W];
    assign half_out = sum_low[`HALF_BIT+1];

    // result selection by operation
    always_comb
    begin
        case (op_code)
            exec_pkg::add_immediate, exec_pkg::add_register: result = sum_full[DATA_W-1:0];
            exec_pkg::and_immediate, exec_pkg::and_register: result = acc & operand;
            exec_pkg::bit_clear_op: result = operand & ~bit_mask;
            exec_pkg::bit_set_op: result = operand | bit_mask;
            default: result = operand;
        endcase
    end

    assign zero_out = (result == '0);

endmodule

// ===== src/add_and_bit_ops_exec.sv
// executor for add, and, bit clear/set and bit-test-skip operations
`timescale 1ns/1ns
`include "exec_map.svh"

// Behaviour
// - add immediate into accumulator, update all flags
// - add register, route result, update all flags
// - destination 0 accumulator, 1 register
// - and immediate into accumulator, zero flag only
// - and register to destination, zero flag only
// - bit clear in register, flags untouched
// - bit set in register, flags untouched
// - skip next when bit one, two periods
// - skip next when bit zero, two periods
// - port operands read from pin levels
module add_and_bit_ops_exec #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic op_valid,
    input wire exec_pkg::op_t op_code,
    input wire logic [DATA_W-1:0] literal,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic dest_sel,
    input wire logic [2:0] bit_idx,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic reg_is_port,
    input wire logic [DATA_W-1:0] pin_level,
    output logic [DATA_W-1:0] acc_ff,
    output logic carry_ff,
    output logic half_sum_overflow_ff,
    output logic zero_ff,
    output logic reg_wr_en_ff,
    output logic [ADDR_W-1:0] reg_wr_addr_ff,
    output logic [DATA_W-1:0] reg_wr_data_ff,
    output logic squash_ff,
    output logic op_done_ff
);

    //--------------------------------------------------------------
    // declarations
    //--------------------------------------------------------------
    exec_pkg::exec_state_t state_ff;
    logic [DATA_W-1:0] pin_meta_ff, pin_sync_ff, pin_chk_ff, pin_stable_ff;
    logic [DATA_W-1:0] operand, reg_value, alu_result;
    logic alu_carry, alu_half, alu_zero, exec, tested_bit, skip_taken;
    logic is_imm, is_reg_alu, is_bit_op, to_acc, to_reg, is_add;

    //--------------------------------------------------------------
    // pin synchroniser
    //--------------------------------------------------------------
    // three stages; a pin change counts once stages two and three agree
    always_ff @(posedge ref_clk)
    begin
        pin_meta_ff <= pin_level;
        pin_sync_ff <= pin_meta_ff;
        pin_chk_ff <= pin_sync_ff;
    end

    // per-bit acceptance of agreed levels
    genvar gb;
    generate
        for (gb = 0; gb < DATA_W; gb = gb + 1)
        begin : g_pin
            always_ff @(posedge ref_clk)
            begin
                if (reset)
                    pin_stable_ff[gb] <= 1'h0;
                else if (pin_sync_ff[gb] == pin_chk_ff[gb])
                    pin_stable_ff[gb] <= pin_chk_ff[gb];
            end
        end
    endgenerate

    //--------------------------------------------------------------
    // operand fetch and decode
    //--------------------------------------------------------------
    // forward a pending write-back so the next op sees it
    assign reg_value = (reg_wr_en_ff && reg_wr_addr_ff == reg_addr) ? reg_wr_data_ff : reg_rdata;
    // port registers read the pins, not the latch
    assign operand = (op_code == exec_pkg::add_immediate || op_code == exec_pkg::and_immediate) ? literal
                   : (reg_is_port ? pin_stable_ff : reg_value);

    assign exec = op_valid && (state_ff == exec_pkg::run_st);
    assign is_imm = (op_code == exec_pkg::add_immediate) || (op_code == exec_pkg::and_immediate);
    assign is_reg_alu = (op_code == exec_pkg::add_register) || (op_code == exec_pkg::and_register);
    assign is_bit_op = (op_code == exec_pkg::bit_clear_op) || (op_code == exec_pkg::bit_set_op);
    assign is_add = (op_code == exec_pkg::add_immediate) || (op_code == exec_pkg::add_register);
    assign to_acc = exec && (is_imm || (is_reg_alu && dest_sel == `DEST_ACC));
    assign to_reg = exec && ((is_reg_alu && dest_sel == `DEST_REG) || is_bit_op);
    assign tested_bit = operand[bit_idx];
    assign skip_taken = exec && ((op_code == exec_pkg::skip_if_bit_one && tested_bit)
                      || (op_code == exec_pkg::skip_if_bit_zero && !tested_bit));

    alu_core #(
        .DATA_W(DATA_W)
    ) u_alu (
        .op_code(op_code),
        .acc(acc_ff),
        .operand(operand),
        .bit_idx(bit_idx),
        .result(alu_result),
        .carry_out(alu_carry),
        .half_out(alu_half),
        .zero_out(alu_zero)
    );

    //--------------------------------------------------------------
    // sequencing
    //--------------------------------------------------------------
    // a taken skip squashes the next presented instruction
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_ff <= exec_pkg::run_st;
            squash_ff <= 1'h0;
        end
        else
        begin
            case (state_ff)
                exec_pkg::run_st:
                begin
                    if (skip_taken)
                    begin
                        state_ff <= exec_pkg::squash_st;
                        squash_ff <= 1'h1;
                    end
                end
                exec_pkg::squash_st:
                begin
                    if (op_valid)
                    begin
                        state_ff <= exec_pkg::run_st; // discarded slot executes nothing, op_done_ff stays low
                        squash_ff <= 1'h0;
                    end
                end
                default:
                begin
                    state_ff <= exec_pkg::run_st;
                    squash_ff <= 1'h0;
                end
            endcase
        end
    end

    // completion pulse for every executed, unsquashed op
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            op_done_ff <= 1'h0;
        else
            op_done_ff <= exec;
    end

    //--------------------------------------------------------------
    // accumulator and status flags
    //--------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            acc_ff <= `ACC_RESET;
        else if (to_acc)
            acc_ff <= alu_result;
    end

    // only add touches carry and half carry; add and and touch zero
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            carry_ff <= `FLAG_RESET;
            half_sum_overflow_ff <= `FLAG_RESET;
            zero_ff <= `FLAG_RESET;
        end
        else if (exec && (is_imm || is_reg_alu))
        begin
            if (is_add)
            begin
                carry_ff <= alu_carry;
                half_sum_overflow_ff <= alu_half;
            end
            zero_ff <= alu_zero;
        end
    end

    //--------------------------------------------------------------
    // register write-back
    //--------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            reg_wr_en_ff <= 1'h0;
            reg_wr_addr_ff <= '0;
            reg_wr_data_ff <= '0;
        end
        else
        begin
            reg_wr_en_ff <= to_reg;
            if (to_reg)
            begin
                reg_wr_addr_ff <= reg_addr;
                reg_wr_data_ff <= alu_result;
            end
        end
    end

    //--------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------
    logic [DATA_W:0] chk_sum;
    assign chk_sum = {1'h0, acc_ff} + {1'h0, operand};

    sequence s_skip_hit;
        skip_taken;
    endsequence
    sequence s_discard;
        squash_ff && op_valid ##1 !reg_wr_en_ff && !op_done_ff && !squash_ff;
    endsequence

    property p_add_imm;
        @(posedge ref_clk) disable iff (reset)
        exec && op_code == exec_pkg::add_immediate |=> acc_ff == DATA_W'($past(acc_ff) + $past(literal));
    endproperty
    a_add_imm: assert property (p_add_imm) else $error("add immediate result wrong");
    property p_add_reg;
        @(posedge ref_clk) disable iff (reset)
        exec && op_code == exec_pkg::add_register |=> carry_ff == $past(chk_sum[DATA_W])
            && zero_ff == ($past(chk_sum[DATA_W-1:0]) == '0);
    endproperty
    a_add_reg: assert property (p_add_reg) else $error("add register flags wrong");
    property p_dest_reg;
        @(posedge ref_clk) disable iff (reset)
        exec && is_reg_alu && dest_sel |=> reg_wr_en_ff && reg_wr_addr_ff == $past(reg_addr) && $stable(acc_ff);
    endproperty
    a_dest_reg: assert property (p_dest_reg) else $error("register destination not honoured");
    property p_and_imm;
        @(posedge ref_clk) disable iff (reset)
        exec && op_code == exec_pkg::and_immediate |=> acc_ff == ($past(acc_ff) & $past(literal))
            && $stable(carry_ff) && $stable(half_sum_overflow_ff);
    endproperty
    a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");
    property p_and_reg;
        @(posedge ref_clk) disable iff (reset)
        exec && op_code == exec_pkg::and_register && dest_sel |=> reg_wr_data_ff == ($past(acc_ff) & $past(operand))
            && $stable(carry_ff) && $stable(half_sum_overflow_ff);
    endproperty
    a_and_reg: assert property (p_and_reg) else $error("and register wrong");
    property p_bit_clear;
        @(posedge ref_clk) disable iff (reset)
        exec && op_code == exec_pkg::bit_clear_op |=> reg_wr_en_ff && !reg_wr_data_ff[$past(bit_idx)]
            && $stable(zero_ff) && $stable(carry_ff);
    endproperty
    a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");
    // other seven bits: compare with the indexed bit forced high on both sides
    property p_bit_set;
        @(posedge ref_clk) disable iff (reset)
        exec && op_code == exec_pkg::bit_set_op |=> reg_wr_data_ff[$past(bit_idx)]
            && (reg_wr_data_ff | DATA_W'(1 << $past(bit_idx))) == ($past(operand) | DATA_W'(1 << $past(bit_idx)))
            && $stable(zero_ff);
    endproperty
    a_bit_set: assert property (p_bit_set) else $error("bit set wrong");
    property p_skip;
        @(posedge ref_clk) disable iff (reset)
        s_skip_hit |=> squash_ff && $stable(zero_ff) && $stable(carry_ff);
    endproperty
    a_skip: assert property (p_skip) else $error("skip not taken");
    property p_discard;
        @(posedge ref_clk) disable iff (reset)
        squash_ff && op_valid |-> s_discard;
    endproperty
    a_discard: assert property (p_discard) else $error("skipped op not discarded");
    property p_no_skip;
        @(posedge ref_clk) disable iff (reset)
        exec && op_code == exec_pkg::skip_if_bit_zero && tested_bit |=> !squash_ff;
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("spurious skip");
    // a port operand must reach the accumulator from the synchronised pins
    property p_port_read;
        @(posedge ref_clk) disable iff (reset)
        exec && reg_is_port && op_code == exec_pkg::and_register && !dest_sel
            |=> acc_ff == ($past(acc_ff) & $past(pin_stable_ff));
    endproperty
    a_port_read: assert property (p_port_read) else $error("port operand not from pins");
    property p_done;
        @(posedge ref_clk) disable iff (reset)
        exec |=> op_done_ff;
    endproperty
    a_done: assert property (p_done) else $error("op did not finish in one cycle");

endmodule

// ===== verification/reg_file_model.sv
// behavioural data register file seen by the executor
`timescale 1ns/1ns

module reg_file_model #(
    parameter logic [6:0] PORT_ADDR = 7'h06
) (
    input wire logic ref_clk,
    input wire logic [6:0] reg_addr,
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rdata,
    output logic is_port
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [7:0] mem [0:127];

    // known start pattern, mirrored by the bench
    initial
    begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i * 7 + 60);
    end

    // write lands one edge after the pulse is seen
    always @(posedge ref_clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

    // port address returns the output latch, not the pins
    assign rdata = mem[reg_addr];
    assign is_port = (reg_addr == PORT_ADDR);
endmodule

// ===== verification/add_and_bit_ops_exec_tb.sv
// self-checking bench for the add and bit-operation executor
`timescale 1ns/1ns

module add_and_bit_ops_exec_tb;
    // ----------------------------------------
    // signals and expectations
    // ----------------------------------------
    localparam logic [6:0] PORT_ADDR = 7'h06;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic op_valid = 1'b0;
    exec_pkg::op_t op_code = exec_pkg::idle_op;
    logic [7:0] literal = 8'h00;
    logic [6:0] reg_addr = 7'h00;
    logic dest_sel = 1'b0;
    logic [2:0] bit_idx = 3'h0;
    logic [7:0] pin_level = 8'h00;
    logic [7:0] reg_rdata, acc_ff, reg_wr_data_ff;
    logic reg_is_port, carry_ff, half_sum_overflow_ff, zero_ff, reg_wr_en_ff, squash_ff, op_done_ff;
    logic [6:0] reg_wr_addr_ff;
    logic [7:0] e_acc = 8'h00, e_wd = 8'h00, pins = 8'h00;
    logic [6:0] e_wa = 7'h00;
    logic e_c = 1'b0, e_dc = 1'b0, e_z = 1'b0, e_we = 1'b0, e_sq = 1'b0, e_done = 1'b0;
    logic [7:0] mem [0:127];
    int fail_count = 0;
    int check_count = 0;

    add_and_bit_ops_exec dut (.ref_clk(ref_clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
        .literal(literal), .reg_addr(reg_addr), .dest_sel(dest_sel), .bit_idx(bit_idx),
        .reg_rdata(reg_rdata), .reg_is_port(reg_is_port), .pin_level(pin_level), .acc_ff(acc_ff),
        .carry_ff(carry_ff), .half_sum_overflow_ff(half_sum_overflow_ff), .zero_ff(zero_ff),
        .reg_wr_en_ff(reg_wr_en_ff), .reg_wr_addr_ff(reg_wr_addr_ff), .reg_wr_data_ff(reg_wr_data_ff),
        .squash_ff(squash_ff), .op_done_ff(op_done_ff));

    reg_file_model #(.PORT_ADDR(PORT_ADDR)) partner (.ref_clk(ref_clk), .reg_addr(reg_addr),
        .wr_en(reg_wr_en_ff), .wr_addr(reg_wr_addr_ff), .wr_data(reg_wr_data_ff),
        .rdata(reg_rdata), .is_port(reg_is_port));

    // 100 ns clock
    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // checking helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // returns {half carry, carry, sum}
    function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b);
        logic [4:0] h;
        logic [8:0] s;
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        s = {1'b0, a} + {1'b0, b};
        return {h[4], s};
    endfunction

    // present one op, check the previous one, then predict this one
    task automatic do_op(input exec_pkg::op_t op, input logic v, input logic [7:0] lit,
        input logic [6:0] a, input logic d, input logic [2:0] b);
        logic [7:0] opd, res;
        logic alu, ar, wr;
        @(posedge ref_clk);
        op_valid <= v;
        op_code <= op;
        literal <= lit;
        reg_addr <= a;
        dest_sel <= d;
        bit_idx <= b;
        pin_level <= pins;
        #1;
        check(acc_ff, e_acc);
        check(8'(carry_ff), 8'(e_c));
        check(8'(half_sum_overflow_ff), 8'(e_dc));
        check(8'(zero_ff), 8'(e_z));
        check(8'(reg_wr_en_ff), 8'(e_we));
        check(8'(reg_wr_addr_ff), 8'(e_wa));
        check(reg_wr_data_ff, e_wd);
        check(8'(squash_ff), 8'(e_sq));
        check(8'(op_done_ff), 8'(e_done));
        opd = (a == PORT_ADDR) ? pins : mem[a];
        res = opd;
        e_we = 1'b0;
        e_done = 1'b0;
        alu = (op >= exec_pkg::add_immediate) && (op <= exec_pkg::and_register);
        ar = (op == exec_pkg::add_register) || (op == exec_pkg::and_register);
        if (v && e_sq)
            e_sq = 1'b0;
        else if (v)
        begin
            e_done = 1'b1;
            case (op)
                exec_pkg::add_immediate: {e_dc, e_c, res} = add8(e_acc, lit);
                exec_pkg::add_register: {e_dc, e_c, res} = add8(e_acc, opd);
                exec_pkg::and_immediate: res = e_acc & lit;
                exec_pkg::and_register: res = e_acc & opd;
                exec_pkg::bit_clear_op: res[b] = 1'b0;
                exec_pkg::bit_set_op: res[b] = 1'b1;
                exec_pkg::skip_if_bit_one: e_sq = opd[b];
                exec_pkg::skip_if_bit_zero: e_sq = !opd[b];
                default: ;
            endcase
            wr = (ar && d) || op == exec_pkg::bit_clear_op || op == exec_pkg::bit_set_op;
            if (alu)
                e_z = (res == 8'h00);
            if (alu && !wr)
                e_acc = res;
            if (wr)
                {e_we, e_wa, e_wd, mem[a]} = {1'b1, a, res, res};
        end
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(74740));
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i * 7 + 60);
        pins = 8'($urandom());
        pin_level <= pins;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (6) do_op(exec_pkg::idle_op, 1'b0, 8'h00, 7'h00, 1'b0, 3'h0);
        do_op(exec_pkg::add_immediate, 1'b1, 8'hFF, 7'h00, 1'b0, 3'h0);
        do_op(exec_pkg::add_immediate, 1'b1, 8'h01, 7'h00, 1'b0, 3'h0);
        do_op(exec_pkg::and_immediate, 1'b1, 8'h5A, 7'h00, 1'b0, 3'h0);
        do_op(exec_pkg::bit_set_op, 1'b1, 8'h00, 7'h7F, 1'b0, 3'h7);
        do_op(exec_pkg::skip_if_bit_one, 1'b1, 8'h00, 7'h7F, 1'b0, 3'h7);
        do_op(exec_pkg::add_immediate, 1'b1, 8'h11, 7'h00, 1'b0, 3'h0);
        do_op(exec_pkg::bit_clear_op, 1'b1, 8'h00, 7'h7F, 1'b0, 3'h0);
        do_op(exec_pkg::skip_if_bit_zero, 1'b1, 8'h00, 7'h7F, 1'b0, 3'h0);
        do_op(exec_pkg::idle_op, 1'b0, 8'h00, 7'h00, 1'b0, 3'h0);
        do_op(exec_pkg::add_register, 1'b1, 8'h00, 7'h7F, 1'b1, 3'h0);
        do_op(exec_pkg::add_register, 1'b1, 8'h00, PORT_ADDR, 1'b1, 3'h0);
        do_op(exec_pkg::and_register, 1'b1, 8'h00, PORT_ADDR, 1'b0, 3'h0);
        for (int k = 0; k < 3; k++)
        begin
            pins = 8'($urandom());
            repeat (6) do_op(exec_pkg::idle_op, 1'b0, 8'h00, 7'h00, 1'b0, 3'h0);
            repeat (200) do_op(exec_pkg::op_t'($urandom_range(0, 8)), ($urandom_range(0, 7) != 0),
                8'($urandom()), $urandom_range(0, 1) ? 7'($urandom()) : 7'($urandom_range(4, 7)),
                1'($urandom()), 3'($urandom()));
        end
        do_op(exec_pkg::idle_op, 1'b0, 8'h00, 7'h00, 1'b0, 3'h0);
        conclude();
    end

    // hang guard, about four times the expected run
    initial
    begin
        repeat (2500) @(posedge ref_clk);
        fail_count++;
        conclude();
    end
endmodule
